// >>> src/ehsp_pkg.sv
// constants and helpers for the host serial port of the panel controller
// assumes every pin of the host link is sampled by sys_clk, 50 MHz
//
// Contract
// - traffic counts only while host select is low; otherwise ignored
// - command/data flag high means parameter, low means command opcode
// - busy output low while waveform, otp programming or sensor access runs
// - strap low selects four-wire; strap high selects nine-bit three-wire
// - data sampled on serial clock rising edge, msb first, byte units
// - surplus parameter bytes beyond a command's defined count are discarded
// - three-wire unit is nine bits: flag first, then eight payload bits
// - serial bit counter cleared on every rising edge of host select
// - three-wire read: msb driven after first falling clock when flag high
// - four-wire: flag from command/data line, units eight clocks long
// - four-wire read: msb driven after select falls when flag line high
// - three-wire dual: flag first on primary line, units five clocks
// - four-wire dual: flag from line, byte over four clocks, two lines
// - dual modes never drive either data line
// - device held in reset while reset input low
package ehsp_pkg;

    typedef enum logic [1:0] {
        EHSP_MD_4W,
        EHSP_MD_3W,
        EHSP_MD_4W_DUAL,
        EHSP_MD_3W_DUAL
    } ehsp_mode_t;

    typedef enum logic [1:0] {
        EHSP_RD_IDLE,
        EHSP_RD_ARMED,
        EHSP_RD_SHIFT
    } ehsp_rd_state_t;

    // clocks per transfer unit
    localparam logic [3:0] EHSP_UNIT_3W      = 4'h9;
    localparam logic [3:0] EHSP_UNIT_4W      = 4'h8;
    localparam logic [3:0] EHSP_UNIT_3W_DUAL = 4'h5;
    localparam logic [3:0] EHSP_UNIT_4W_DUAL = 4'h4;

    localparam logic [7:0] EHSP_OP_DUAL      = 8'h15;
    localparam int         EHSP_DUAL_EN_BIT  = 4;
    localparam logic [7:0] EHSP_PARAM_ANY    = 8'hFF;
    localparam logic       EHSP_DUAL_RST     = 1'b0;

    localparam int         EHSP_FIFO_W       = 9;
    localparam int         EHSP_FIFO_DEPTH   = 16;
    localparam int         EHSP_SYNC_W       = 6;

    // defined parameter count per opcode; unknown and streams take any count
    function automatic logic [7:0] ehsp_param_count(input logic [7:0] op);
        case (op)
            8'h00: ehsp_param_count = 8'h01;
            8'h01: ehsp_param_count = 8'h05;
            8'h02: ehsp_param_count = 8'h00;
            8'h03: ehsp_param_count = 8'h01;
            8'h04: ehsp_param_count = 8'h00;
            8'h06: ehsp_param_count = 8'h04;
            8'h07: ehsp_param_count = 8'h01;
            8'h11: ehsp_param_count = 8'h00;
            8'h12: ehsp_param_count = 8'h00;
            8'h15: ehsp_param_count = 8'h01;
            8'h17: ehsp_param_count = 8'h01;
            8'h20: ehsp_param_count = 8'h3C;
            8'h21: ehsp_param_count = 8'h2A;
            8'h50: ehsp_param_count = 8'h01;
            8'h60: ehsp_param_count = 8'h01;
            8'h61: ehsp_param_count = 8'h04;
            8'h65: ehsp_param_count = 8'h04;
            8'h82: ehsp_param_count = 8'h01;
            8'h90: ehsp_param_count = 8'h09;
            default: ehsp_param_count = EHSP_PARAM_ANY;
        endcase
    endfunction : ehsp_param_count

endpackage : ehsp_pkg

// >>> src/ehsp_fifo.sv
// receive fifo between the serial front end and the command core
// assumes both sides run on sys_clk; output word held in a register
`timescale 1ns/1ps
module ehsp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // filling side
    input  wire logic             s_valid,
    output logic                  s_ready,
    input  wire logic [WIDTH-1:0] s_data,
    // draining side
    output logic                  m_valid,
    input  wire logic             m_ready,
    output logic      [WIDTH-1:0] m_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    wire              push    = s_valid & s_ready;
    wire              take    = out_valid_q & m_ready;
    wire              refill  = (~out_valid_q | take) & (cnt_q != '0);

    assign s_ready = (cnt_q != (AW+1)'(DEPTH));
    assign m_valid = out_valid_q;
    assign m_data  = out_data_q;
    assign cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(refill);

    always_ff @(posedge sys_clk) begin
        if (push)
            mem[wr_ptr_q] <= s_data;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            cnt_q       <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (refill) begin
                out_data_q  <= mem[rd_ptr_q];
                rd_ptr_q    <= rd_ptr_q + 1'b1;
                out_valid_q <= 1'b1;
            end else if (take) begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule : ehsp_fifo

// >>> src/ehsp_serial_port.sv
// host serial port: receives command and parameter units, returns read data
// assumes the host link pins are asynchronous to sys_clk and that the
// serial clock runs well below a quarter of sys_clk
`timescale 1ns/1ps
module ehsp_serial_port (
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           arst_n,
    // host link pins
    input  wire logic                           host_select_n,
    input  wire logic                           host_sclk,
    input  wire logic                           cmd_data_line,
    input  wire logic                           iface_strap,
    input  wire logic                           sda_in,
    output logic                                sda_out,
    output logic                                sda_oe_n,
    input  wire logic                           second_data_line,
    output logic                                busy_n,
    // internal activity sources
    input  wire logic                           wave_active,
    input  wire logic                           otp_active,
    input  wire logic                           temp_active,
    // read data from the command core
    input  wire logic                           rd_enable,
    input  wire logic [7:0]                     rd_data,
    output logic                                rd_take,
    // received units: bit 8 set for a parameter
    output logic                                rx_valid,
    input  wire logic                           rx_ready,
    output logic [ehsp_pkg::EHSP_FIFO_W-1:0]    rx_data,
    output logic                                rx_overrun,
    output logic                                dual_mode
);
    import ehsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [EHSP_SYNC_W-1:0] meta_q;
    logic [EHSP_SYNC_W-1:0] sync_q;
    logic                   sclk_prev_q;
    logic                   sel_prev_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // select idles high, serial clock idles low: no false edge
            meta_q      <= 6'h1;
            sync_q      <= 6'h1;
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b1;
        end else begin
            meta_q      <= {second_data_line, sda_in, iface_strap, cmd_data_line,
                            host_sclk, host_select_n};
            sync_q      <= meta_q;
            sclk_prev_q <= sync_q[1];
            sel_prev_q  <= sync_q[0];
        end
    end

    wire sel_n_s   = sync_q[0];
    wire sclk_s    = sync_q[1];
    wire cd_s      = sync_q[2];
    wire strap_s   = sync_q[3];
    wire sda_s     = sync_q[4];
    wire second_data_line_s    = sync_q[5];
    wire active    = ~sel_n_s;
    wire sclk_rise = active & sclk_s & ~sclk_prev_q;
    wire sclk_fall = active & ~sclk_s & sclk_prev_q;
    wire sel_rise  = sel_n_s & ~sel_prev_q;
    wire sel_fall  = ~sel_n_s & sel_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // mode and unit length
    logic       dual_q;
    ehsp_mode_t mode;
    logic [3:0] unit_len;
    wire        three_wire = strap_s;

    assign mode = three_wire ? (dual_q ? EHSP_MD_3W_DUAL : EHSP_MD_3W)
                             : (dual_q ? EHSP_MD_4W_DUAL : EHSP_MD_4W);

    always_comb begin
        case (mode)
            EHSP_MD_3W:      unit_len = EHSP_UNIT_3W;
            EHSP_MD_4W:      unit_len = EHSP_UNIT_4W;
            EHSP_MD_3W_DUAL: unit_len = EHSP_UNIT_3W_DUAL;
            EHSP_MD_4W_DUAL: unit_len = EHSP_UNIT_4W_DUAL;
            default:         unit_len = EHSP_UNIT_4W;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // receive shifter
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic       flag_q;
    logic       read_unit_q;

    // three-wire units carry the flag in their first clock
    wire        first_clk  = (bit_cnt_q == 4'h0);
    wire        flag_clk   = three_wire & first_clk;
    wire [7:0]  shift_d    = dual_q ? {shift_q[5:0], sda_s, second_data_line_s}
                                    : {shift_q[6:0], sda_s};
    wire        unit_done  = sclk_rise & (bit_cnt_q == unit_len - 4'h1);
    wire        unit_flag  = three_wire ? flag_q : cd_s;
    wire [7:0]  unit_byte  = shift_d;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            flag_q    <= 1'b0;
        end else if (sel_n_s) begin
            bit_cnt_q <= 4'h0;
        end else if (sclk_rise) begin
            bit_cnt_q <= unit_done ? 4'h0 : bit_cnt_q + 4'h1;
            if (flag_clk)
                flag_q <= sda_s;
            else
                shift_q <= shift_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command tracking and parameter limit
    logic [7:0] opcode_q;
    logic [7:0] limit_q;
    logic [7:0] param_cnt_q;
    wire        is_param   = unit_flag;
    wire        under_lim  = (limit_q == EHSP_PARAM_ANY) | (param_cnt_q < limit_q);
    wire        keep_unit  = unit_done & ~read_unit_q & (~is_param | under_lim);
    wire        dual_cfg   = keep_unit & is_param & (opcode_q == EHSP_OP_DUAL);
    logic       fifo_ready;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            opcode_q    <= 8'h00;
            limit_q     <= EHSP_PARAM_ANY;
            param_cnt_q <= 8'h00;
            dual_q      <= EHSP_DUAL_RST;
        end else if (keep_unit) begin
            if (!is_param) begin
                opcode_q    <= unit_byte;
                limit_q     <= ehsp_param_count(unit_byte);
                param_cnt_q <= 8'h00;
            end else begin
                param_cnt_q <= param_cnt_q + 8'h01;
            end
            if (dual_cfg)
                dual_q <= unit_byte[EHSP_DUAL_EN_BIT];
        end
    end

    // a full fifo drops the unit; busy warns the host beforehand
    logic overrun_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            overrun_q <= 1'b0;
        else if (keep_unit & ~fifo_ready)
            overrun_q <= 1'b1;
    end

    ehsp_fifo #(
        .WIDTH (EHSP_FIFO_W),
        .DEPTH (EHSP_FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .s_valid (keep_unit),
        .s_ready (fifo_ready),
        .s_data  ({is_param, unit_byte}),
        .m_valid (rx_valid),
        .m_ready (rx_ready),
        .m_data  (rx_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // read return on the primary data line
    ehsp_rd_state_t rd_state_q;
    logic [7:0]     rd_shift_q;
    logic           sda_out_q;
    logic           sda_oe_n_q;
    logic           rd_take_q;

    // dual modes never answer reads
    wire rd_allowed = rd_enable & ~dual_q;
    wire start_4w   = sel_fall & ~three_wire & cd_s & rd_allowed;
    wire arm_3w     = sclk_rise & flag_clk & sda_s & rd_allowed;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_state_q  <= EHSP_RD_IDLE;
            rd_shift_q  <= 8'h00;
            sda_out_q   <= 1'b0;
            sda_oe_n_q  <= 1'b1;
            rd_take_q   <= 1'b0;
            read_unit_q <= 1'b0;
        end else begin
            rd_take_q <= 1'b0;
            if (sel_n_s) begin
                rd_state_q  <= EHSP_RD_IDLE;
                sda_oe_n_q  <= 1'b1;
                read_unit_q <= 1'b0;
            end else begin
                case (rd_state_q)
                    EHSP_RD_IDLE: begin
                        if (start_4w) begin
                            rd_state_q  <= EHSP_RD_SHIFT;
                            sda_out_q   <= rd_data[7];
                            rd_shift_q  <= {rd_data[6:0], 1'b0};
                            sda_oe_n_q  <= 1'b0;
                            rd_take_q   <= 1'b1;
                            read_unit_q <= 1'b1;
                        end else if (arm_3w) begin
                            rd_state_q  <= EHSP_RD_ARMED;
                            read_unit_q <= 1'b1;
                        end
                    end
                    EHSP_RD_ARMED: begin
                        if (sclk_fall) begin
                            rd_state_q <= EHSP_RD_SHIFT;
                            sda_out_q  <= rd_data[7];
                            rd_shift_q <= {rd_data[6:0], 1'b0};
                            sda_oe_n_q <= 1'b0;
                            rd_take_q  <= 1'b1;
                        end
                    end
                    EHSP_RD_SHIFT: begin
                        // unit end without select rise: next byte reads afresh only in three-wire
                        if (unit_done) begin
                            rd_state_q <= EHSP_RD_IDLE;
                        end else if (sclk_fall) begin
                            sda_out_q  <= rd_shift_q[7];
                            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
                        end
                    end
                    default: rd_state_q <= EHSP_RD_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy output, also lowered while the fifo is full
    logic busy_n_q;
    wire  fifo_busy = ~fifo_ready;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            busy_n_q <= 1'b1;
        else
            busy_n_q <= ~(wave_active | otp_active | temp_active | fifo_busy);
    end

    logic dual_out_q;
    logic overrun_out_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dual_out_q    <= 1'b0;
            overrun_out_q <= 1'b0;
        end else begin
            dual_out_q    <= dual_q;
            overrun_out_q <= overrun_q;
        end
    end

    assign sda_out    = sda_out_q;
    assign sda_oe_n   = sda_oe_n_q;
    assign rd_take    = rd_take_q;
    assign busy_n     = busy_n_q;
    assign dual_mode  = dual_out_q;
    assign rx_overrun = overrun_out_q;
endmodule : ehsp_serial_port

// >>> tb/ehsp_serial_port_props.sv
// checker for the host serial port: busy, read drive and receive handshake
// assumes it is bound to ehsp_serial_port and sees only that module's ports
`timescale 1ns/1ps
module ehsp_serial_port_props (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       arst_n,
    // link pins
    input wire logic       host_select_n,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       busy_n,
    // activity and core side
    input wire logic       wave_active,
    input wire logic       otp_active,
    input wire logic       temp_active,
    input wire logic       rd_enable,
    input wire logic [7:0] rd_data,
    input wire logic       rd_take,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [8:0] rx_data,
    input wire logic       dual_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////
    property p_busy;
        (wave_active || otp_active || temp_active) |=> !busy_n;
    endproperty
    a_busy: assert property (p_busy) else $error("busy_n high during activity");
    property p_busy_cause;
        $fell(busy_n) |-> $past(wave_active) || $past(otp_active) || $past(temp_active) || rx_valid;
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy_n low without cause");
    property p_dual_quiet;
        dual_mode |-> sda_oe_n && !rd_take;
    endproperty
    a_dual_quiet: assert property (p_dual_quiet) else $error("data line driven in dual");
    property p_oe_sel;
        $fell(sda_oe_n) |-> !$past(host_select_n, 2);
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("drive began while deselected");
    property p_oe_release;
        ($rose(host_select_n) && !sda_oe_n) |-> ##[2:6] sda_oe_n;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("data line not released");
    property p_rd_start;
        $fell(sda_oe_n) |-> rd_take && (sda_out == $past(rd_data[7]));
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("first read bit not msb");
    property p_rd_pulse;
        rd_take |-> $past(rd_enable) ##1 !rd_take;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("rd_take not a single pulse");
    property p_rx_hold;
        (rx_valid && !rx_ready) |=> rx_valid && $stable(rx_data);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("unit changed before taken");
    c_read: cover property ($fell(sda_oe_n));
    c_dual: cover property ($rose(dual_mode));
    c_busy: cover property ($fell(busy_n) && rx_valid && !wave_active);
endmodule : ehsp_serial_port_props

bind ehsp_serial_port ehsp_serial_port_props u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .host_select_n(host_select_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .busy_n(busy_n), .wave_active(wave_active),
    .otp_active(otp_active), .temp_active(temp_active), .rd_enable(rd_enable),
    .rd_data(rd_data), .rd_take(rd_take), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .dual_mode(dual_mode)
);

// >>> tb/ehsp_host_model.sv
// host microcontroller model: frames units and reads over the serial link
// assumes sys_clk only for frame alignment; link clock 160 ns, still between frames
`timescale 1ns/1ps
module ehsp_host_model (
    // timing and status
    input  wire logic sys_clk,
    input  wire logic busy_n,
    input  wire logic sda_line,
    // link drive
    output logic      host_select_n,
    output logic      host_sclk,
    output logic      cmd_data_line,
    output logic      host_sda,
    output logic      host_sec,
    output logic      host_en
);
    import ehsp_pkg::*;
    initial begin
        host_select_n = 1'b1;
        host_sclk     = 1'b0;
        cmd_data_line = 1'b0;
        host_sda      = 1'b0;
        host_sec      = 1'b0;
        host_en       = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic edge_pair(input logic a, input logic b);
        host_sda = a;
        host_sec = b;
        #80;
        host_sclk = 1'b1;
        #80;
        host_sclk = 1'b0;
    endtask : edge_pair
    task automatic open_frame(input logic sel, input logic cd, input logic drv);
        int n;
        // bounded: a refusal scenario sends anyway once the wait runs out
        for (n = 0; n < 2000 && busy_n !== 1'b1; n++) @(negedge sys_clk);
        @(negedge sys_clk);
        #7;
        host_select_n = !sel;
        cmd_data_line = cd;
        host_en = drv;
    endtask : open_frame
    task automatic close_frame();
        #80;
        host_select_n = 1'b1;
        host_en = 1'b0;
        #80;
    endtask : close_frame
    task automatic unit(input ehsp_mode_t m, input logic cd, input logic [7:0] b,
                        input logic sel, input int n);
        int k;
        logic four;
        four = (m == EHSP_MD_4W) || (m == EHSP_MD_4W_DUAL);
        open_frame(sel, four & cd, 1'b1);
        for (k = 0; k < n; k++) begin
            case (m)
                EHSP_MD_4W: edge_pair(b[7-k], 1'b0);
                EHSP_MD_3W: edge_pair((k == 0) ? cd : b[8-k], 1'b0);
                EHSP_MD_4W_DUAL: edge_pair(b[7-2*k], b[6-2*k]);
                default: edge_pair((k == 0) ? cd : b[9-2*k], (k == 0) ? 1'b0 : b[8-2*k]);
            endcase
        end
        close_frame();
    endtask : unit
    task automatic read_unit(input logic three, output logic [7:0] d);
        int k;
        open_frame(1'b1, !three, three);
        if (three) edge_pair(1'b1, 1'b0);
        host_en = 1'b0;
        for (k = 0; k < 8; k++) begin
            #80;
            host_sclk = 1'b1;
            // sampled late in the high phase, clear of the device's output lag
            #80;
            d[7-k] = sda_line;
            host_sclk = 1'b0;
        end
        close_frame();
    endtask : read_unit
endmodule : ehsp_host_model

// >>> tb/testbench.sv
// self-checking bench for the host serial port driven by the host model
// assumes ehsp_pkg and the design files are compiled first
`timescale 1ns/1ps
module testbench;
    import ehsp_pkg::*;
    logic       sys_clk, arst_n, iface_strap, rd_enable, rx_ready, pat;
    logic       sda_out, sda_oe_n, busy_n, rd_take, rx_valid, rx_overrun, dual_mode;
    logic       sel_n, sclk, cd, h_sda, h_sec, h_en;
    logic [2:0] act;
    logic [7:0] rd_data, d;
    logic [8:0] rx_data;
    wire        sda_w, sec_w;
    int         fail_count, compares, i, takes;
    // a released line toggles, so a stale value cannot pass
    assign sda_w = (sda_oe_n === 1'b0) ? sda_out : (h_en ? h_sda : pat);
    assign sec_w = h_en ? h_sec : pat;
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) pat <= ~pat;
    always @(posedge sys_clk) if (rd_take === 1'b1) takes <= takes + 1;
    ehsp_serial_port DUT (
        .sys_clk(sys_clk), .arst_n(arst_n), .host_select_n(sel_n), .host_sclk(sclk),
        .cmd_data_line(cd), .iface_strap(iface_strap), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .second_data_line(sec_w), .busy_n(busy_n),
        .wave_active(act[2]), .otp_active(act[1]), .temp_active(act[0]),
        .rd_enable(rd_enable), .rd_data(rd_data), .rd_take(rd_take), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun), .dual_mode(dual_mode)
    );
    ehsp_host_model hst (
        .sys_clk(sys_clk), .busy_n(busy_n), .sda_line(sda_w), .host_select_n(sel_n),
        .host_sclk(sclk), .cmd_data_line(cd), .host_sda(h_sda), .host_sec(h_sec), .host_en(h_en)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task automatic pop(input logic [8:0] exp);
        int n;
        @(negedge sys_clk);
        for (n = 0; n < 400 && rx_valid !== 1'b1; n++) @(negedge sys_clk);
        if (rx_valid !== 1'b1) begin
            chk("rx_valid", 9'h001, {8'h00, rx_valid});
            finish_test();
        end
        chk("rx_data", exp, rx_data);
        rx_ready = 1'b1;
        @(negedge sys_clk);
        rx_ready = 1'b0;
    endtask : pop
    task automatic none();
        repeat (20) @(negedge sys_clk);
        chk("rx_valid", 9'h000, {8'h00, rx_valid});
    endtask : none
    task automatic t_reset();
        chk("sda_oe_n", 9'h001, {8'h00, sda_oe_n});
        chk("dual_mode", 9'h000, {8'h00, dual_mode});
        chk("busy_n", 9'h001, {8'h00, busy_n});
    endtask : t_reset
    task automatic t_write4();
        hst.unit(EHSP_MD_4W, 1'b0, 8'h03, 1'b1, 8);
        pop(9'h003);
        for (i = 0; i < 2; i++) hst.unit(EHSP_MD_4W, 1'b1, 8'h5A + i[7:0], 1'b1, 8);
        pop(9'h15A);
        none();
        hst.unit(EHSP_MD_4W, 1'b0, 8'h21, 1'b0, 8);
        none();
        hst.unit(EHSP_MD_4W, 1'b0, 8'hFF, 1'b1, 3);
        hst.unit(EHSP_MD_4W, 1'b0, 8'h10, 1'b1, 8);
        pop(9'h010);
    endtask : t_write4
    task automatic t_write3();
        @(negedge sys_clk);
        iface_strap = 1'b1;
        hst.unit(EHSP_MD_3W, 1'b0, 8'h10, 1'b1, 9);
        hst.unit(EHSP_MD_3W, 1'b1, 8'hA7, 1'b1, 9);
        pop(9'h010);
        pop(9'h1A7);
    endtask : t_write3
    task automatic t_read();
        @(negedge sys_clk);
        rd_enable = 1'b1;
        rd_data = 8'hC3;
        iface_strap = 1'b0;
        hst.read_unit(1'b0, d);
        chk("read4", 9'h0C3, {1'b0, d});
        repeat (2) @(negedge sys_clk);
        chk("sda_oe_n", 9'h001, {8'h00, sda_oe_n});
        iface_strap = 1'b1;
        rd_data = 8'h96;
        hst.read_unit(1'b1, d);
        chk("read3", 9'h096, {1'b0, d});
        chk("rd_take", 9'h002, takes[8:0]);
        @(negedge sys_clk);
        rd_enable = 1'b0;
        none();
    endtask : t_read
    task automatic t_busy();
        for (i = 0; i < 3; i++) begin
            @(negedge sys_clk);
            act = 3'b001 << i;
            repeat (2) @(negedge sys_clk);
            chk("busy_n", 9'h000, {8'h00, busy_n});
            act = 3'b000;
            repeat (3) @(negedge sys_clk);
            chk("busy_n", 9'h001, {8'h00, busy_n});
        end
    endtask : t_busy
    task automatic t_fifo();
        @(negedge sys_clk);
        iface_strap = 1'b0;
        for (i = 0; i < 18; i++) hst.unit(EHSP_MD_4W, i > 0, (i == 0) ? 8'h10 : i[7:0], 1'b1, 8);
        chk("busy_n", 9'h000, {8'h00, busy_n});
        chk("rx_overrun", 9'h001, {8'h00, rx_overrun});
        for (i = 0; i < 17; i++) pop((i == 0) ? 9'h010 : {1'b1, i[7:0]});
        none();
    endtask : t_fifo
    task automatic t_dual();
        hst.unit(EHSP_MD_4W, 1'b0, EHSP_OP_DUAL, 1'b1, 8);
        hst.unit(EHSP_MD_4W, 1'b1, 8'h10, 1'b1, 8);
        pop({1'b0, EHSP_OP_DUAL});
        pop(9'h110);
        chk("dual_mode", 9'h001, {8'h00, dual_mode});
        @(negedge sys_clk);
        rd_enable = 1'b1;
        hst.unit(EHSP_MD_4W_DUAL, 1'b0, 8'h10, 1'b1, 4);
        hst.unit(EHSP_MD_4W_DUAL, 1'b1, 8'h9C, 1'b1, 4);
        pop(9'h010);
        pop(9'h19C);
        @(negedge sys_clk);
        iface_strap = 1'b1;
        hst.unit(EHSP_MD_3W_DUAL, 1'b1, 8'h63, 1'b1, 5);
        pop(9'h163);
    endtask : t_dual
    initial begin
        arst_n = 1'b0;
        iface_strap = 1'b0;
        rd_enable = 1'b0;
        rx_ready = 1'b0;
        pat = 1'b0;
        act = 3'b000;
        rd_data = 8'h00;
        fail_count = 0;
        compares = 0;
        takes = 0;
        repeat (5) @(negedge sys_clk);
        t_reset();
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_write4();
        t_write3();
        t_read();
        t_busy();
        t_fifo();
        t_dual();
        finish_test();
    end
endmodule : testbench
